/* File: sid_decoder.sv */
// sid_decoder.sv: instruction register and decoder of the scan port
// assumes: tap state events come from a tap controller on test_clk;
// the control chain is loaded by that controller's data scans
`include "sid_map.svh"

// Overview of operation
// - unlisted opcodes, including 81/05/88 family codes, act as bypass, normal mode
// - bit 7 is parity; defined opcodes hold even count of ones
// - 00 and 03 select boundary chain, test mode, pins and core captured
// - bypass selects one-bit bypass register, captures zero, normal operation
// - sample/preload selects boundary chain in normal mode, captures pins and core
// - highz selects bypass, outputs float, inputs and core keep working
// - clamp selects bypass in test mode, cells drive core and pins
// - run test selects bypass, test mode, runs control op in idle
// - control chain decodes five run-test operations
// - read instructions select boundary chain and leave it unchanged at capture
// - cell self test selects boundary chain, normal mode, cells capture inverse
// - toggle outputs inverts output shift cells each rising edge in idle
// - toggle outputs holds input cells, no pin capture, test mode
// - control scans select control chain and leave it unchanged at capture
// - reset gives all ones, capture-ir loads 10000001
// - new instruction takes effect only at update-ir
// - control chain resets to 00000000010, op in low bits, masks above

module sid_decoder (
   input wire logic test_clk,
   input wire logic reset_n,
   input wire logic ref_clk,
   input wire logic tdi,
   input wire sid_pkg::sid_tap_t tap,
   input wire logic ctl_capture,
   input wire logic ctl_shift,
   input wire logic ctl_update,
   output logic ir_tdo,
   output logic [`SID_IR_W-1:0] instr,
   output logic [`SID_CTL_W-1:0] ctl_chain,
   output sid_pkg::sid_ctrl_t ctrl,
   output logic route_test,
   output logic outputs_float,
   output logic [1:0] mode_sync
);

   // --------------------------------------------------------------
   // instruction register
   // --------------------------------------------------------------
   logic [`SID_IR_W-1:0] ir_shift_r;
   logic [`SID_IR_W-1:0] ir_hold_r;

   always_ff @(posedge test_clk or negedge reset_n) begin
      if (!reset_n) begin
         ir_shift_r <= `SID_IR_RESET;
      end else if (tap.test_reset) begin
         ir_shift_r <= `SID_IR_RESET;
      end else if (tap.capture_ir) begin
         ir_shift_r <= `SID_IR_CAPTURE;
      end else if (tap.shift_ir) begin
         ir_shift_r <= {tdi, ir_shift_r[`SID_IR_W-1:1]};
      end
   end

   // shadow updates on falling edge after update-ir
   always_ff @(negedge test_clk or negedge reset_n) begin
      if (!reset_n) begin
         ir_hold_r <= `SID_IR_RESET;
      end else if (tap.test_reset) begin
         ir_hold_r <= `SID_IR_RESET;
      end else if (tap.update_ir) begin
         ir_hold_r <= ir_shift_r;
      end
   end

   assign ir_tdo = ir_shift_r[0];
   assign instr = ir_hold_r;

   // --------------------------------------------------------------
   // run-test control chain
   // --------------------------------------------------------------
   logic [`SID_CTL_W-1:0] ctl_shift_r;
   logic [`SID_CTL_W-1:0] ctl_hold_r;
   logic ctl_sel;

   assign ctl_sel = (ctrl.sel == sid_pkg::SID_SEL_CONTROL);

   always_ff @(posedge test_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl_shift_r <= `SID_CTL_RESET;
      end else if (tap.test_reset) begin
         ctl_shift_r <= `SID_CTL_RESET;
      end else if (ctl_sel && ctl_capture) begin
         ctl_shift_r <= ctl_hold_r;
      end else if (ctl_sel && ctl_shift) begin
         ctl_shift_r <= {tdi, ctl_shift_r[`SID_CTL_W-1:1]};
      end
   end

   always_ff @(negedge test_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl_hold_r <= `SID_CTL_RESET;
      end else if (tap.test_reset) begin
         ctl_hold_r <= `SID_CTL_RESET;
      end else if (ctl_sel && ctl_update) begin
         ctl_hold_r <= ctl_shift_r;
      end
   end

   assign ctl_chain = ctl_shift_r;

   // --------------------------------------------------------------
   // run-test operation decode
   // --------------------------------------------------------------
   sid_pkg::sid_run_t ctl_op;

   always_comb begin
      unique case (ctl_hold_r[`SID_CTL_OP_MSB:`SID_CTL_OP_LSB])
         `SID_RT_SIPTOG: ctl_op = sid_pkg::SID_RUN_SIPTOG;
         `SID_RT_PSEUDO_RANDOM_PATTERN_OP: ctl_op = sid_pkg::SID_RUN_PSEUDO_RANDOM_PATTERN_OP;
         `SID_RT_PSA: ctl_op = sid_pkg::SID_RUN_PSA;
         `SID_RT_PSAPRPG: ctl_op = sid_pkg::SID_RUN_PSAPRPG;
         `SID_RT_PSACNT: ctl_op = sid_pkg::SID_RUN_PSACNT;
         default: ctl_op = sid_pkg::SID_RUN_NONE;
      endcase
   end

   // --------------------------------------------------------------
   // instruction decode
   // --------------------------------------------------------------
   always_comb begin
      ctrl.sel = sid_pkg::SID_SEL_BYPASS;
      ctrl.mode = sid_pkg::SID_MODE_NORMAL;
      ctrl.cap = sid_pkg::SID_CAP_ZERO;
      ctrl.run = sid_pkg::SID_RUN_NONE;
      ctrl.in_mask = ctl_hold_r[`SID_CTL_MASK_MSB:`SID_CTL_MASK_LSB];
      // only even-parity codes are listed; others fall to default
      unique case (ir_hold_r)
         `SID_OP_BSCAN0, `SID_OP_BSCAN3: begin
            ctrl.sel = sid_pkg::SID_SEL_BOUNDARY;
            ctrl.mode = sid_pkg::SID_MODE_TEST;
            ctrl.cap = sid_pkg::SID_CAP_PINS_CORE;
         end
         `SID_OP_SAMPLE: begin
            ctrl.sel = sid_pkg::SID_SEL_BOUNDARY;
            ctrl.cap = sid_pkg::SID_CAP_PINS_CORE;
         end
         `SID_OP_HIGHZ: begin
            ctrl.mode = sid_pkg::SID_MODE_HIGHZ;
         end
         `SID_OP_CLAMP: begin
            ctrl.mode = sid_pkg::SID_MODE_TEST;
         end
         `SID_OP_RUN_TEST_INSTR: begin
            ctrl.mode = sid_pkg::SID_MODE_TEST;
            ctrl.run = tap.run_idle ? ctl_op : sid_pkg::SID_RUN_NONE;
         end
         `SID_OP_RD_NORM: begin
            ctrl.sel = sid_pkg::SID_SEL_BOUNDARY;
            ctrl.cap = sid_pkg::SID_CAP_HOLD;
         end
         `SID_OP_RD_TEST: begin
            ctrl.sel = sid_pkg::SID_SEL_BOUNDARY;
            ctrl.mode = sid_pkg::SID_MODE_TEST;
            ctrl.cap = sid_pkg::SID_CAP_HOLD;
         end
         `SID_OP_SELFTST: begin
            ctrl.sel = sid_pkg::SID_SEL_BOUNDARY;
            ctrl.cap = sid_pkg::SID_CAP_INVERT;
         end
         `SID_OP_TOGGLE: begin
            ctrl.mode = sid_pkg::SID_MODE_TEST;
            ctrl.run = tap.run_idle ? sid_pkg::SID_RUN_TOGGLE : sid_pkg::SID_RUN_NONE;
         end
         `SID_OP_CSCAN_N: begin
            ctrl.sel = sid_pkg::SID_SEL_CONTROL;
            ctrl.cap = sid_pkg::SID_CAP_HOLD;
         end
         `SID_OP_CSCAN_T: begin
            ctrl.sel = sid_pkg::SID_SEL_CONTROL;
            ctrl.mode = sid_pkg::SID_MODE_TEST;
            ctrl.cap = sid_pkg::SID_CAP_HOLD;
         end
         default: begin
            ctrl.sel = sid_pkg::SID_SEL_BYPASS;
         end
      endcase
   end

   assign route_test = (ctrl.mode == sid_pkg::SID_MODE_TEST);
   assign outputs_float = (ctrl.mode == sid_pkg::SID_MODE_HIGHZ);

   // --------------------------------------------------------------
   // mode crossing to the system clock
   // --------------------------------------------------------------
   logic [1:0] mode_s1_r;
   logic [1:0] mode_s2_r;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_s1_r <= 2'h0;
         mode_s2_r <= 2'h0;
      end else begin
         mode_s1_r <= {outputs_float, route_test};
         mode_s2_r <= mode_s1_r;
      end
   end

   assign mode_sync = mode_s2_r;

endmodule

/* File: sid_map.svh */
// sid_map.svh: opcode, chain and reset constants for the scan instruction decoder
// assumes: included by sid_pkg.sv and the decoder module; definitions only
`ifndef SID_MAP_SVH
`define SID_MAP_SVH

`define SID_IR_W 8
`define SID_CTL_W 11
`define SID_IR_RESET 8'hff
`define SID_IR_CAPTURE 8'h81
`define SID_CTL_RESET 11'h002
`define SID_CTL_OP_LSB 0
`define SID_CTL_OP_MSB 2
`define SID_CTL_MASK_LSB 3
`define SID_CTL_MASK_MSB 10

`define SID_OP_BSCAN0 8'h00
`define SID_OP_BYPASS 8'h81
`define SID_OP_SAMPLE 8'h82
`define SID_OP_BSCAN3 8'h03
`define SID_OP_HIGHZ 8'h06
`define SID_OP_CLAMP 8'h87
`define SID_OP_RUN_TEST_INSTR 8'h09
`define SID_OP_RD_NORM 8'h0a
`define SID_OP_RD_TEST 8'h8b
`define SID_OP_SELFTST 8'h0c
`define SID_OP_TOGGLE 8'h8d
`define SID_OP_CSCAN_N 8'h8e
`define SID_OP_CSCAN_T 8'h0f

`define SID_RT_SIPTOG 3'h0
`define SID_RT_PSEUDO_RANDOM_PATTERN_OP 3'h1
`define SID_RT_PSA 3'h2
`define SID_RT_PSAPRPG 3'h3
`define SID_RT_PSACNT 3'h4

`endif

/* File: sid_pkg.sv */
// sid_pkg.sv: types shared by the scan instruction decoder
// assumes: sid_map.svh provides the widths
`include "sid_map.svh"

package sid_pkg;

   typedef enum logic [1:0] {
      SID_SEL_BYPASS,
      SID_SEL_BOUNDARY,
      SID_SEL_CONTROL
   } sid_sel_t;

   typedef enum logic [1:0] {
      SID_MODE_NORMAL,
      SID_MODE_TEST,
      SID_MODE_HIGHZ
   } sid_mode_t;

   // what the selected chain loads at capture-dr
   typedef enum logic [2:0] {
      SID_CAP_ZERO,
      SID_CAP_PINS_CORE,
      SID_CAP_HOLD,
      SID_CAP_INVERT,
      SID_CAP_NONE
   } sid_cap_t;

   typedef enum logic [2:0] {
      SID_RUN_NONE,
      SID_RUN_TOGGLE,
      SID_RUN_SIPTOG,
      SID_RUN_PSEUDO_RANDOM_PATTERN_OP,
      SID_RUN_PSA,
      SID_RUN_PSAPRPG,
      SID_RUN_PSACNT
   } sid_run_t;

   // tap state events seen by the decoder
   typedef struct packed {
      logic test_reset;
      logic capture_ir;
      logic shift_ir;
      logic update_ir;
      logic run_idle;
   } sid_tap_t;

   // decoded control for the data path
   typedef struct packed {
      sid_sel_t sel;
      sid_mode_t mode;
      sid_cap_t cap;
      sid_run_t run;
      logic [7:0] in_mask;
   } sid_ctrl_t;

endpackage

/* File: sid_decoder_assertions.sv */
// sid_decoder_assertions.sv: port checks of the scan instruction decoder
// assumes: bound to sid_decoder; tap levels change just after rising test_clk
module sid_decoder_chk (
   input wire logic test_clk,
   input wire logic reset_n,
   input wire logic ref_clk,
   input wire sid_pkg::sid_tap_t tap,
   input wire logic ir_tdo,
   input wire logic [7:0] instr,
   input wire sid_pkg::sid_ctrl_t ctrl,
   input wire logic route_test,
   input wire logic outputs_float,
   input wire logic [1:0] mode_sync
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [6:0] d;
   // sel, mode and capture as one code
   assign d = {ctrl.sel, ctrl.mode, ctrl.cap};
   default clocking dc @(negedge test_clk);
   endclocking
   default disable iff (!reset_n);
   sequence ir_capture_shift;
      tap.capture_ir && !tap.test_reset ##1 tap.shift_ir;
   endsequence
   a_unlisted_bypass: assert property (!(instr inside {8'h00, 8'h03, 8'h81, 8'h82, 8'h06,
      8'h87, 8'h09, 8'h0a, 8'h8b, 8'h0c, 8'h8d, 8'h8e, 8'h0f}) |-> d == 7'h00) else $error("bad bypass");
   a_boundary_test: assert property (instr inside {8'h00, 8'h03} |-> d == 7'h29)
      else $error("bad boundary scan");
   a_sample_normal: assert property (instr == 8'h82 |-> d == 7'h21) else $error("bad sample");
   a_highz_float: assert property (instr == 8'h06 |-> d == 7'h10 && outputs_float)
      else $error("bad highz");
   a_clamp_run_test: assert property (instr inside {8'h87, 8'h09, 8'h8d} |-> d == 7'h08
      && route_test) else $error("bad clamp or run decode");
   a_read_hold: assert property (instr inside {8'h0a, 8'h8b} |-> d == (instr[7] ? 7'h2a : 7'h22))
      else $error("bad read decode");
   a_self_invert: assert property (instr == 8'h0c |-> d == 7'h23) else $error("bad self test");
   a_ctl_scan: assert property (instr inside {8'h8e, 8'h0f} |-> d == (instr[7] ? 7'h42 : 7'h4a))
      else $error("bad control scan");
   a_toggle_run: assert property (tap.run_idle && instr == 8'h8d |-> ctrl.run == 3'h1)
      else $error("no toggle in idle");
   a_run_idle_only: assert property (ctrl.run != 3'h0 |-> tap.run_idle && instr[3:0] inside {4'h9, 4'hd})
      else $error("run op outside idle");
   a_capture_ir: assert property (ir_capture_shift |-> ir_tdo ##1 !ir_tdo)
      else $error("capture pattern wrong");
   a_update_only: assert property ($changed(instr) |-> $past(tap.update_ir) || $past(tap.test_reset))
      else $error("instr changed without update");
   a_mode_sync: assert property (@(posedge ref_clk) disable iff (!reset_n)
      mode_sync == $past({outputs_float, route_test}, 2)) else $error("mode sync late");
endmodule

bind sid_decoder sid_decoder_chk u_chk (.test_clk, .reset_n, .ref_clk, .tap, .ir_tdo, .instr,
   .ctrl, .route_test, .outputs_float, .mode_sync);

/* File: sid_tap_model.sv */
// sid_tap_model.sv: behavioural test controller driving the decoder's tap side
// assumes: bench gives test_clk and calls the scan tasks
module sid_tap_model (
   input wire logic test_clk,
   output logic tdi,
   output sid_pkg::sid_tap_t tap,
   output logic [2:0] ctl
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      tdi = 1'b0;
      tap = '0;
      ctl = 3'h0;
   end
   // one state per cycle; tdi flips when unused
   task automatic step(logic [4:0] t, logic [2:0] c, logic b);
      @(posedge test_clk);
      #1;
      tap = t;
      ctl = c;
      tdi = b;
   endtask
   task automatic scan_ir(logic [7:0] op);
      step(5'h08, 3'h0, ~tdi);
      for (int i = 0; i < 8; i++) step(5'h04, 3'h0, op[i]);
      step(5'h02, 3'h0, ~tdi);
      step(5'h00, 3'h0, ~tdi);
   endtask
   task automatic scan_ctl(logic [10:0] v);
      step(5'h00, 3'h4, ~tdi);
      for (int i = 0; i < 11; i++) step(5'h00, 3'h2, v[i]);
      step(5'h00, 3'h1, ~tdi);
      step(5'h00, 3'h0, ~tdi);
   endtask
   task automatic hold(logic [4:0] t);
      step(t, 3'h0, ~tdi);
      step(5'h00, 3'h0, ~tdi);
   endtask
endmodule

/* File: scan_instruction_decoder_test.sv */
// scan_instruction_decoder_test.sv: self-checking bench of the decoder
// assumes: sid_tap_model drives the tap side; checker bound separately
module scan_instruction_decoder_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'b0, test_clk = 1'b0, reset_n = 1'b0, tdi, ir_tdo, route_test, outputs_float;
   logic [2:0] ctl;
   logic [7:0] instr, mask = 8'h00;
   logic [10:0] ctl_chain, v;
   logic [1:0] mode_sync;
   sid_pkg::sid_tap_t tap;
   sid_pkg::sid_ctrl_t ctrl;
   logic [25:0] exp_q[$];
   int failures = 0, samples_checked = 0;
   integer seed = 32'h67fd;
   const logic [7:0] ops[17] = '{8'h00, 8'h81, 8'h82, 8'h03, 8'h84, 8'h05, 8'h06, 8'h87, 8'h88,
      8'h09, 8'h0a, 8'h8b, 8'h0c, 8'h8d, 8'h8e, 8'h0f, 8'hff};
   always #10 ref_clk = ~ref_clk;
   initial begin
      #3.3;
      forever #7.5 test_clk = ~test_clk;
   end
   sid_tap_model m (.test_clk, .tdi, .tap, .ctl);
   sid_decoder dut (.test_clk, .reset_n, .ref_clk, .tdi, .tap, .ctl_capture(ctl[2]),
      .ctl_shift(ctl[1]), .ctl_update(ctl[0]), .ir_tdo, .instr, .ctl_chain, .ctrl, .route_test,
      .outputs_float, .mode_sync);
   // sel, mode and capture code per opcode
   function automatic logic [6:0] dec(logic [7:0] op);
      case (op)
         8'h00, 8'h03: return 7'h29;
         8'h82: return 7'h21;
         8'h06: return 7'h10;
         8'h87, 8'h09, 8'h8d: return 7'h08;
         8'h0a: return 7'h22;
         8'h8b: return 7'h2a;
         8'h0c: return 7'h23;
         8'h8e: return 7'h42;
         8'h0f: return 7'h4a;
         default: return 7'h00;
      endcase
   endfunction
   task automatic chk(logic [25:0] got, logic [25:0] want);
      samples_checked++;
      if (got !== want) begin
         failures++;
         $display("[ERR] %0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic ir(logic [7:0] op);
      logic [6:0] c;
      c = dec(op);
      exp_q.push_back({op, c, 3'h0, mask});
      m.scan_ir(op);
      repeat (3) @(posedge ref_clk);
      #1;
      chk(mode_sync, {c[4:3] == 2'h2, c[4:3] == 2'h1});
   endtask
   task automatic idle(logic [7:0] op, logic [2:0] r);
      exp_q.push_back({op, dec(op), r, mask});
      m.hold(5'h01);
   endtask
   task automatic close_out();
      $display("compared %0d mismatched %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(negedge test_clk)
      if (tap.update_ir | tap.run_idle | tap.test_reset) begin
         #1;
         if (exp_q.size() > 0) chk({instr, ctrl}, exp_q.pop_front());
      end
   // whole run is some 13 us
   initial begin
      #500000;
      failures++;
      close_out();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
      chk({instr, ctl_chain}, {8'hff, 11'h002});
      foreach (ops[i]) ir(ops[i]);
      ir(8'h8d);
      idle(8'h8d, 3'h1);
      repeat (8) ir(8'($random(seed)));
      $display("opcode tests done");
      for (int o = 0; o < 8; o++) begin
         v = {8'($random(seed)), o[2:0]};
         ir(o[0] ? 8'h0f : 8'h8e);
         m.scan_ctl(v);
         mask = v[10:3];
         chk(ctl_chain, v);
         ir(8'h09);
         idle(8'h09, o < 5 ? o[2:0] + 3'h2 : 3'h0);
         m.scan_ctl(~v);
         chk(ctl_chain, v);
      end
      $display("run test ops done");
      ir(8'h0c);
      mask = 8'h00;
      exp_q.push_back({8'hff, 18'h0});
      m.hold(5'h10);
      chk(ctl_chain, 11'h002);
      repeat (4) @(posedge test_clk);
      $display("reset test done");
      close_out();
   end
endmodule
